/* File: core/dmr0_dram.sv */
// Device end: decodes the first mode register and tracks update timing.
// Assumes the link clock and link signals come from another domain.
//
// Summary of operation
// - Only deselects allowed during tMOD after MRS
// - DLL and similar updates exempt from tMOD
// - ODT low DODTLoff plus one before MRS
// - Latency, parity, gear-down, RTT changes need ODT low
// - Unchanged ODT-timing values need no ODT low
// - MRS only when idle with CKE high
// - ODT held low until tMOD expires
// - Ignore ODT when RTT_NOM stays disabled
// - Reserved bits of register written zero
// - A8 requests DLL reset, A7 test
// - WR plus tRP gives auto-precharge delay
// - A11:A9 encode write recovery and read-to-precharge
// - A3 selects sequential or interleaved order
// - DLL reset self-clears; wait tDLLK
// - Test bit one is vendor-only mode
`timescale 1ns/10ps
module dmr0_dram
    import dmr0_pkg::*;
#(
    parameter int TMOD = TMOD_NCK,
    parameter int TDLLK = TDLLK_NCK,
    parameter int TRP = TRP_NCK
) (
    input wire logic clk,
    input wire logic arst_n,
    dmr0_link_if.dram link,
    input wire logic [4:0] additive_latency,
    input wire logic rtt_nom_enabled,
    output logic [1:0] burst_length_select,
    output logic burst_order_select,
    output logic [4:0] cas_latency_select,
    output logic vendor_test_select,
    output logic [4:0] write_recovery_cycles,
    output logic [3:0] read_to_precharge_cycles,
    output logic [5:0] auto_precharge_cycles,
    output logic [5:0] read_latency,
    output logic dll_reset_pulse,
    output logic dll_locked,
    output logic tmod_busy,
    output logic odt_term_on,
    output logic cmd_violation,
    output logic field_violation
);
    initial begin
        if (TMOD < 1 || TMOD >= 2**CNT_W || TDLLK < 1 ||
            TDLLK >= 2**CNT_W || TRP < 1 || TRP > 40)
            $error("dmr0_dram: timing parameter out of range");
    end

    // ============================================================
    // Field decoders
    // CAS latency code, zero for a reserved code
    function automatic logic [4:0] cl_decode(input logic [3:0] c);
        logic [4:0] r;
        r = 5'h00;
        unique case (c)
            4'hd: r = 5'h11;
            4'h8: r = 5'h12;
            4'he: r = 5'h13;
            4'h9: r = 5'h14;
            4'hf: r = 5'h15;
            4'ha: r = 5'h16;
            4'hb, 4'hc: r = 5'h00;
            default: r = 5'(c) + 5'h09;
        endcase
        return r;
    endfunction

    // Write recovery code, zero for the reserved code
    function automatic logic [4:0] wr_decode(input logic [2:0] c);
        logic [4:0] r;
        r = 5'h00;
        unique case (c)
            3'h7: r = 5'h16;
            3'h6: r = 5'h00;
            default: r = 5'h0a + {1'b0, c, 1'b0};
        endcase
        return r;
    endfunction

    // ============================================================
    // Link capture
    logic [LINK_W-1:0] raw;
    logic [LINK_W-1:0] syn;
    logic ck_d;
    assign raw = {link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n,
        link.we_n, link.bg0, link.ba, link.addr, link.odt};

    dmr0_sync #(.W(LINK_W)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(raw),
        .q(syn)
    );

    // Link clock edge follows the synchronised copy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ck_d <= 1'b0;
        end else begin
            ck_d <= syn[23];
        end
    end

    // ============================================================
    // Command decode
    wire ck_rise = syn[23] & ~ck_d;
    wire s_cke = syn[22];
    wire s_cs_n = syn[21];
    wire [2:0] s_rcw = syn[20:18];
    wire [2:0] s_sel = syn[17:15];
    wire [ADDR_W-1:0] s_a = syn[14:1];
    wire s_odt = syn[0];
    wire is_mrs = ck_rise & ~s_cs_n & (s_rcw == 3'h0);
    wire is_read = ck_rise & ~s_cs_n & (s_rcw == 3'h5);
    wire is_other = ck_rise & ~s_cs_n & ~is_mrs;
    wire mr0_hit = is_mrs & (s_sel == 3'h0);
    wire [3:0] cl_code = {s_a[6:4], s_a[2]};
    wire [2:0] wr_code = s_a[WR_LSB+2:WR_LSB];
    wire [4:0] cl_val = cl_decode(cl_code);
    wire [4:0] wr_val = wr_decode(wr_code);
    wire dll_req = mr0_hit & s_a[DLLRST_BIT];
    wire bad_field = ((s_a & MR0_RSV_MASK) != 14'h0) | (cl_val == 5'h00) |
        (wr_val == 5'h00) | (s_a[1:0] == BL_RESERVED);

    // ============================================================
    // Decoded register contents
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            burst_length_select <= 2'h0;
            burst_order_select <= 1'b0;
            cas_latency_select <= 5'h09;
            vendor_test_select <= 1'b0;
            write_recovery_cycles <= 5'h0a;
            read_to_precharge_cycles <= 4'h5;
        end else if (mr0_hit) begin
            burst_length_select <= s_a[BL_LSB+1:BL_LSB];
            burst_order_select <= s_a[ORDER_BIT];
            cas_latency_select <= cl_val;
            vendor_test_select <= s_a[TEST_BIT];
            write_recovery_cycles <= wr_val;
            read_to_precharge_cycles <= wr_val[4:1];
        end
    end

    // Derived latencies follow the stored codes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            auto_precharge_cycles <= 6'h00;
            read_latency <= 6'h00;
        end else begin
            auto_precharge_cycles <= 6'(write_recovery_cycles) +
                6'(TRP);
            read_latency <= 6'(additive_latency) +
                6'(cas_latency_select);
        end
    end

    // ============================================================
    // Update window after MRS
    logic [CNT_W-1:0] tmod_cnt;
    logic exempt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tmod_cnt <= '0;
            exempt <= 1'b0;
        end else if (is_mrs) begin
            tmod_cnt <= CNT_W'(TMOD);
            exempt <= dll_req;
        end else if (ck_rise && tmod_cnt != '0) begin
            tmod_cnt <= tmod_cnt - 1'b1;
        end
    end

    // DLL reset bit clears itself; lock counted in link clocks
    logic [CNT_W-1:0] lock_cnt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dll_reset_pulse <= 1'b0;
            dll_locked <= 1'b0;
            lock_cnt <= '0;
        end else begin
            dll_reset_pulse <= dll_req;
            if (dll_req) begin
                dll_locked <= 1'b0;
                lock_cnt <= CNT_W'(TDLLK);
            end else if (ck_rise && lock_cnt != '0) begin
                lock_cnt <= lock_cnt - 1'b1;
                dll_locked <= (lock_cnt == CNT_W'(1));
            end
        end
    end

    // ============================================================
    // Termination and sticky protocol checks
    logic rtt_prev;
    wire in_window = (tmod_cnt != '0) & ~exempt;
    wire odt_ignored = is_mrs & ~rtt_prev & ~rtt_nom_enabled;
    wire cmd_bad = (is_other & in_window) | (is_mrs & ~s_cke) |
        (is_read & ~dll_locked) |
        (ck_rise & s_odt & in_window & rtt_nom_enabled);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rtt_prev <= 1'b0;
            odt_term_on <= 1'b0;
            tmod_busy <= 1'b0;
            cmd_violation <= 1'b0;
            field_violation <= 1'b0;
        end else begin
            rtt_prev <= rtt_nom_enabled;
            if (ck_rise)
                odt_term_on <= s_odt & rtt_nom_enabled & ~odt_ignored;
            tmod_busy <= (tmod_cnt != '0);
            cmd_violation <= cmd_violation | cmd_bad;
            field_violation <= field_violation |
                (mr0_hit & bad_field);
        end
    end
endmodule

/* File: shared/dmr0_pkg.sv */
// Constants shared by both ends of the mode register update link.
// Assumes one system clock; link counts are in link clock cycles.
package dmr0_pkg;
    // ============================================================
    // Link timing
    localparam int CK_DIV = 8;          // System clocks per link clock
    localparam int TMOD_NCK = 24;       // MRS to non-MRS delay, link clocks
    localparam int DODTLOFF_NCK = 8;    // ODT turn-off latency, link clocks
    localparam int TDLLK_NCK = 64;      // DLL lock time, link clocks
    localparam int TRP_NCK = 14;        // Precharge time, link clocks
    localparam int CNT_W = 16;
    // ============================================================
    // Link widths and mode register field positions
    localparam int ADDR_W = 14;
    localparam int LINK_W = 24;         // Bits carried through the syncs
    localparam int BL_LSB = 0;
    localparam int ORDER_BIT = 3;
    localparam int TEST_BIT = 7;
    localparam int DLLRST_BIT = 8;
    localparam int WR_LSB = 9;
    localparam logic [13:0] MR0_RSV_MASK = 14'h3080;
    localparam logic [1:0] BL_RESERVED = 2'h3;
    // ============================================================
    // Controller registers (APB byte offsets)
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_MRWORD = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam int CTRL_START = 0;
    localparam int CTRL_RTT_ON = 1;
    localparam int CTRL_ODT_REQ = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [16:0] MRWORD_RESET = 17'h00000;
    localparam int MRWORD_SEL_LSB = 14; // {bg0, ba1, ba0} above address
    // ============================================================
    // Controller sequencer states
    typedef enum logic [3:0] {
        DMR0_IDLE = 4'b0001,
        DMR0_WAIT_IDLE = 4'b0010,
        DMR0_ODT_OFF = 4'b0100,
        DMR0_HOLD = 4'b1000
    } dmr0_state_e;
endpackage

/* File: shared/dmr0_link_if.sv */
// Command/address link between the controller and the memory device.
// Assumes the controller drives every signal, the device only listens.
`timescale 1ns/10ps
interface dmr0_link_if;
    import dmr0_pkg::*;
    logic ck;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bg0;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic odt;
    modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, bg0, ba, addr,
        odt);
    modport dram (input ck, cke, cs_n, ras_n, cas_n, we_n, bg0, ba, addr,
        odt);
endinterface

/* File: core/dmr0_sync.sv */
// Two flip-flop synchroniser for a bundle of link inputs.
// Assumes the bundle changes well away from the sampled clock edge.
`timescale 1ns/10ps
module dmr0_sync #(
    parameter int W = 24
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    // First stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* File: core/dmr0_ctrl.sv */
// Controller end: sequences one mode register write per APB start.
// Assumes an APB master on clk and a device listening on the link.
`timescale 1ns/10ps
module dmr0_ctrl
    import dmr0_pkg::*;
#(
    parameter int DIV = CK_DIV,
    parameter int TMOD = TMOD_NCK,
    parameter int DODTLOFF = DODTLOFF_NCK,
    parameter int TDLLK = TDLLK_NCK
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic all_banks_idle,
    dmr0_link_if.ctrl link
);
    initial begin
        if (DIV < 2 || DIV > 255 || DIV % 2 != 0 || TMOD < 1 ||
            DODTLOFF < 0 || TDLLK < 1 || TDLLK >= 2**CNT_W)
            $error("dmr0_ctrl: parameter out of range");
    end

    // ============================================================
    // Link clock divider; outputs change as the link clock falls
    logic [7:0] div_cnt;
    wire fall_en = (div_cnt == 8'(DIV/2 - 1));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 8'h00;
            link.ck <= 1'b1;
        end else begin
            div_cnt <= (div_cnt == 8'(DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
            link.ck <= (div_cnt == 8'(DIV - 1)) | (div_cnt < 8'(DIV/2 - 1));
        end
    end

    // ============================================================
    // APB slave, one wait state per access
    logic [2:0] ctrl;
    logic [16:0] mr_word;
    logic start_pending;
    dmr0_state_e state;
    wire setup_acc = psel & penable & ~pready;
    wire done_acc = psel & penable & pready;
    wire hit_ctrl = (paddr == REG_CTRL);
    wire hit_mr = (paddr == REG_MRWORD);
    wire hit_stat = (paddr == REG_STATUS);
    wire mapped = hit_ctrl | hit_mr | hit_stat;
    wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl} :
        hit_mr ? {15'h0, mr_word} :
        hit_stat ? {28'h0, state} : 32'h0;
    wire start_set = done_acc & pwrite & hit_ctrl & pwdata[CTRL_START];
    wire start_clr = fall_en & (state == DMR0_IDLE);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup_acc;
            pslverr <= setup_acc & ~mapped;
            prdata <= (setup_acc & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    // Register writes take effect at the completing edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= CTRL_RESET;
            mr_word <= MRWORD_RESET;
            start_pending <= 1'b0;
        end else begin
            if (done_acc && pwrite && hit_ctrl)
                ctrl <= {pwdata[2:1], 1'b0};
            if (done_acc && pwrite && hit_mr)
                mr_word <= pwdata[16:0];
            start_pending <= start_set | (start_pending & ~start_clr);
        end
    end

    // ============================================================
    // Sequencer decisions
    wire is_mr0 = (mr_word[16:MRWORD_SEL_LSB] == 3'h0);
    wire [3:0] cl_bits = {mr_word[6:4], mr_word[2]};
    logic [3:0] cl_shadow;
    logic shadow_ok;
    wire cl_changed = ~shadow_ok | (cl_bits != cl_shadow);
    wire need_odt_low = ctrl[CTRL_RTT_ON] | ~is_mr0 |
        cl_changed;
    wire exempt = is_mr0 & mr_word[DLLRST_BIT];
    wire [CNT_W-1:0] hold_len = exempt ? CNT_W'(TDLLK) : CNT_W'(TMOD);
    wire [13:0] cmd_addr = is_mr0 ? (mr_word[13:0] & ~MR0_RSV_MASK) :
        mr_word[13:0];
    logic [CNT_W-1:0] cnt;

    // One-hot sequencer, advances only as the link clock falls
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= DMR0_IDLE;
            cnt <= '0;
        end else if (fall_en) begin
            unique case (state)
                DMR0_IDLE: if (start_pending) state <= DMR0_WAIT_IDLE;
                DMR0_WAIT_IDLE: begin
                    cnt <= '0;
                    if (all_banks_idle && need_odt_low)
                        state <= DMR0_ODT_OFF;
                    else if (all_banks_idle)
                        state <= DMR0_HOLD;
                end
                DMR0_ODT_OFF: begin
                    if (cnt == CNT_W'(DODTLOFF)) begin
                        cnt <= '0;
                        state <= DMR0_HOLD;
                    end else cnt <= cnt + 1'b1;
                end
                DMR0_HOLD: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == hold_len - 1'b1)
                        state <= DMR0_IDLE;
                end
                default: state <= DMR0_IDLE;
            endcase
        end
    end

    // ============================================================
    // Link drive: one MRS cycle, otherwise deselect
    wire launch = fall_en & (((state == DMR0_WAIT_IDLE) & all_banks_idle &
        ~need_odt_low) | ((state == DMR0_ODT_OFF) &
        (cnt == CNT_W'(DODTLOFF))));
    wire odt_free = (state == DMR0_IDLE) | (state == DMR0_WAIT_IDLE &
        ~need_odt_low);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.cke <= 1'b1;
            link.cs_n <= 1'b1;
            {link.ras_n, link.cas_n, link.we_n} <= 3'h7;
            {link.bg0, link.ba} <= 3'h0;
            link.addr <= '0;
            link.odt <= 1'b0;
            cl_shadow <= 4'h0;
            shadow_ok <= 1'b0;
        end else if (fall_en) begin
            link.cs_n <= ~launch;
            {link.ras_n, link.cas_n, link.we_n} <= launch ? 3'h0 : 3'h7;
            if (launch) begin
                {link.bg0, link.ba} <= mr_word[16:MRWORD_SEL_LSB];
                link.addr <= cmd_addr;
            end
            if (launch && is_mr0) begin
                cl_shadow <= cl_bits;
                shadow_ok <= 1'b1;
            end
            link.odt <= odt_free & ctrl[CTRL_ODT_REQ];
        end
    end
endmodule

/* File: sim/dmr0_chk.sv */
// Concurrent checks on the command/address link between the two ends.
// Assumes link signals arrive as plain inputs sampled on the system clock.
`timescale 1ns/10ps
module dmr0_chk
    import dmr0_pkg::*;
#(
    parameter int TMOD = TMOD_NCK,
    parameter int TDLLK = TDLLK_NCK,
    parameter int DODTLOFF = DODTLOFF_NCK
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bg0,
    input wire logic [1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic odt
);
    // ============================================================
    // Helper logic
    logic ck_q;
    logic [7:0] gap_cnt;
    logic [7:0] odt_cnt;
    logic dll_hold;
    logic odt_held;
    // Command decode and link clock rise
    wire mrs = !cs_n && !ras_n && !cas_n && !we_n;
    wire mr0_sel = !bg0 && (ba == 2'h0);
    wire ck_rise = ck && !ck_q;
    // Link clock rises since the last MRS and since odt went low
    wire [7:0] next_gap = mrs ? 8'h00 :
        (ck_rise && gap_cnt != 8'hff) ? gap_cnt + 8'h01 : gap_cnt;
    wire [7:0] next_odt_cnt = odt ? 8'h00 :
        (ck_rise && odt_cnt != 8'hff) ? odt_cnt + 8'h01 : odt_cnt;
    // Counters start saturated: no MRS seen, odt low since reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ck_q <= 1'b1;
            gap_cnt <= 8'hff;
            odt_cnt <= 8'hff;
            dll_hold <= 1'b0;
            odt_held <= 1'b0;
        end else begin
            ck_q <= ck;
            gap_cnt <= next_gap;
            odt_cnt <= next_odt_cnt;
            dll_hold <= mrs ? (mr0_sel && addr[DLLRST_BIT]) : dll_hold;
            odt_held <= mrs ? !odt : odt_held;
        end
    end
    // ============================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    tmod_gap_a: assert property (
        $fell(cs_n) |-> gap_cnt >= TMOD - 1)
        else $error("command issued inside tMOD");
    tdllk_gap_a: assert property (
        $fell(cs_n) && dll_hold |-> gap_cnt >= TDLLK - 1)
        else $error("command issued inside DLL reset wait");
    odt_lead_a: assert property (
        $fell(cs_n) && !odt |-> odt_cnt >= DODTLOFF + 1)
        else $error("odt not low long enough before MRS");
    odt_hold_a: assert property (
        odt_held && !mrs && gap_cnt < TMOD - 1 |-> !odt)
        else $error("odt raised before tMOD expired");
    rsv_zero_a: assert property (
        mrs && mr0_sel |-> (addr & MR0_RSV_MASK) == 14'h0000)
        else $error("reserved or test bit set in MRS");
    cke_high_a: assert property (
        mrs |-> cke)
        else $error("MRS with clock enable low");
    des_after_a: assert property (
        $rose(mrs) |-> mrs[*8] ##1 cs_n[*8])
        else $error("MRS not one link clock then deselect");
    cmd_edge_a: assert property (
        $changed(cs_n) |-> !ck)
        else $error("command changed while link clock high");
    // Main scenarios
    cover property ($fell(cs_n) && !odt);
    cover property ($fell(cs_n) && !mr0_sel);
    cover property ($fell(cs_n) && mr0_sel && addr[DLLRST_BIT]);
endmodule

/* File: sim/tb.sv */
// Self-checking bench: APB master on the controller, device on the link.
// Assumes shortened link counts; expected fields come from a bench model.
`timescale 1ns/10ps
module tb;
    import dmr0_pkg::*;
    localparam int P_TMOD = 4;
    localparam int P_TDLLK = 8;
    localparam int P_DODT = 1;
    localparam logic [3:0] CLC [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
        4'h6, 4'h7, 4'hd, 4'h8, 4'he, 4'h9, 4'hf, 4'ha};
    localparam logic [2:0] WRC [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
        3'h7};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic all_banks_idle = 1'b1;
    logic [4:0] al = 5'h00;
    logic rtt = 1'b0;
    logic [1:0] bls;
    logic bos;
    logic [4:0] cls;
    logic vts;
    logic [4:0] wrs;
    logic [3:0] rtps;
    logic [5:0] aps;
    logic [5:0] rls;
    logic dllp;
    logic dlll;
    logic cmdv;
    logic tmb;
    logic otn;
    logic fv;
    logic [31:0] rd;
    logic er;
    logic cs_q = 1'b1;
    logic [31:0] seed = 32'h000146c0;
    logic [16:0] w;
    logic [16:0] mr_q [$];
    int err_count = 0;
    int n_compared = 0;
    int mrs_cnt = 0;
    int dll_cnt = 0;
    int exp_dll = 0;
    int e_bl = 0;
    int e_ord = 0;
    int e_cl = 9;
    int e_wr = 10;
    // ============================================================
    // Clock, link and instances
    always #20 clk = ~clk;
    dmr0_link_if link();
    dmr0_ctrl #(.DIV(CK_DIV), .TMOD(P_TMOD), .DODTLOFF(P_DODT),
        .TDLLK(P_TDLLK)) dmr0_ctrl_inst (.clk(clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .all_banks_idle(all_banks_idle), .link(link));
    dmr0_dram #(.TMOD(P_TMOD), .TDLLK(P_TDLLK), .TRP(TRP_NCK))
        dmr0_dram_inst (.clk(clk), .arst_n(arst_n), .link(link),
        .additive_latency(al), .rtt_nom_enabled(rtt),
        .burst_length_select(bls), .burst_order_select(bos),
        .cas_latency_select(cls), .vendor_test_select(vts),
        .write_recovery_cycles(wrs), .read_to_precharge_cycles(rtps),
        .auto_precharge_cycles(aps), .read_latency(rls),
        .dll_reset_pulse(dllp), .dll_locked(dlll), .tmod_busy(tmb),
        .odt_term_on(otn), .cmd_violation(cmdv), .field_violation(fv));
    dmr0_chk #(.TMOD(P_TMOD), .TDLLK(P_TDLLK), .DODTLOFF(P_DODT))
        dmr0_chk_inst (.clk(clk), .arst_n(arst_n), .ck(link.ck),
        .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .bg0(link.bg0), .ba(link.ba),
        .addr(link.addr), .odt(link.odt));
    // Counts MRS starts and DLL reset pulses
    always @(posedge clk) begin
        cs_q <= link.cs_n;
        if (cs_q === 1'b1 && link.cs_n === 1'b0) mrs_cnt++;
        if (dllp === 1'b1) dll_cnt++;
    end
    // ============================================================
    // Tasks
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic fail(input string what);
        err_count++;
        $display("BAD %s expected done seen timeout", what);
        results();
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fail("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Programs one mode register word and waits for the sequence to end
    task automatic run_mr(input logic r, input logic o, input logic hold);
        int n;
        int c0;
        apb(1'b1, REG_MRWORD, {15'h0000, w});
        mr_q.push_back(w);
        apb(1'b0, REG_MRWORD, 32'h0);
        check("mrword", {15'h0000, mr_q.pop_front()}, rd);
        all_banks_idle <= !hold;
        rtt <= r;
        c0 = mrs_cnt;
        apb(1'b1, REG_CTRL, {29'h0, o, r, 1'b1});
        if (hold) begin
            repeat (200) @(posedge clk);
            check("mrs while busy", c0, mrs_cnt);
            apb(1'b0, REG_STATUS, 32'h0);
            check("status wait", 32'h2, rd);
            all_banks_idle <= 1'b1;
        end
        for (n = 0; n < 3000 && mrs_cnt == c0; n++) @(posedge clk);
        if (mrs_cnt == c0) fail("mrs");
        if (r) check("odt at mrs", 32'h0, link.odt);
        repeat (12) @(posedge clk);
        check("tmod_busy", 32'h1, tmb);
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd !== 32'h1 && n < 200);
        check("status idle", 32'h1, rd);
        repeat (24) @(posedge clk);
        check("odt after", o, link.odt);
        check("odt_term", o & r, otn);
    endtask
    // Compares device fields with the bench model
    task automatic cmp_dev;
        check("burst_length", e_bl, bls);
        check("burst_order", e_ord, bos);
        check("test_select", 32'h0, vts);
        check("cas_latency", e_cl, cls);
        check("write_recovery", e_wr, wrs);
        check("read_to_pre", e_wr / 2, rtps);
        check("auto_pre", e_wr + TRP_NCK, aps);
        check("read_latency", al + e_cl, rls);
        check("cmd_violation", 32'h0, cmdv);
    endtask
    // ============================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        check("cl reset", 32'h9, cls);
        check("wr reset", 32'ha, wrs);
        check("rtp reset", 32'h5, rtps);
        apb(1'b0, REG_STATUS, 32'h0);
        check("status reset", 32'h1, rd);
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        apb(1'b0, 12'h00c, 32'h0);
        check("unmapped err", 32'h1, er);
        check("unmapped data", 32'h0, rd);
        // Every non-reserved CAS latency and write recovery code, every burst length code
        for (int i = 0; i < 14; i++) begin
            seed = xs(seed);
            al <= {2'h0, seed[2:0]};
            w = seed[16:0];
            w[1:0] = 2'(i % 4);
            w[3] = i[1];
            {w[6], w[5], w[4], w[2]} = CLC[i];
            w[11:9] = WRC[i % 7];
            w[8] = i[0];
            w[16:14] = 3'h0;
            if (w[8]) exp_dll++;
            run_mr(seed[20], seed[21], i == 0);
            e_bl = i % 4;
            e_ord = i[1];
            e_cl = 9 + i;
            e_wr = 10 + 2 * (i % 7);
            cmp_dev();
            check("dll pulses", exp_dll, dll_cnt);
            check("field_violation", i > 2, fv);
        end
        check("dll locked", 32'h1, dlll);
        // A write to another mode register leaves the fields alone
        seed = xs(seed);
        w = {3'h1, seed[13:0]};
        run_mr(1'b1, 1'b1, 1'b0);
        cmp_dev();
        results();
    end
endmodule
